// ---- dps_pkg.sv ----
// constants and types shared by the phase shift control block
package dps_pkg;

	// ==========================================================
	// register map (byte addresses)
	localparam logic [3:0] CTRL_OFFSET = 4'h0;
	localparam logic [3:0] START_OFFSET = 4'h4;
	localparam logic [3:0] STATUS_OFFSET = 4'h8;
	localparam logic [3:0] PHASE_OFFSET = 4'hC;

	// ==========================================================
	// field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_WAIT_BIT = 2;
	localparam int CTRL_RATIO_LSB = 8;
	localparam int STATUS_OVF_BIT = 0;
	localparam int STATUS_LOCK_BIT = 1;
	localparam int STATUS_BUSY_BIT = 2;
	localparam int STATUS_HOLD_BIT = 3;
	localparam int PHASE_FRAC_LSB = 16;

	// ==========================================================
	// modes and step states
	typedef enum logic [1:0] {
		MODE_NONE = 2'b00,
		MODE_FIXED = 2'b01,
		MODE_VARIABLE = 2'b10
	} dps_mode_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SETTLE = 2'b01,
		ST_SYNC = 2'b10,
		ST_DONE = 2'b11
	} dps_step_type;

	// ==========================================================
	// values after reset and limits
	localparam dps_mode_type MODE_RESET = MODE_NONE;
	localparam logic [8:0] START_RESET = 9'h000;
	localparam logic [4:0] RATIO_RESET = 5'h02;
	localparam logic [4:0] RATIO_MIN = 5'h02;
	localparam logic [4:0] RATIO_MAX = 5'h10;
	localparam logic signed [9:0] NUM_MAX = 10'sh0FF;
	localparam logic signed [9:0] NUM_MIN = -10'sh0FF;

	// ==========================================================
	// cycle counts and delay range limit
	localparam int SETTLE_REF_CYCLES = 100;
	localparam int SYNC_STEP_EDGES = 3;
	localparam int LOCK_REF_CYCLES = 64;
	localparam int DELAY_RANGE_LIMIT = 255;

endpackage : dps_pkg

// ---- dps_clock_divider.sv ----
// divided clock output with 50/50 duty cycle
`timescale 1ns/1ps

module dps_clock_divider
	import dps_pkg::*;
#(
	parameter int RATIO_WIDTH = 5
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic [RATIO_WIDTH-1:0] ratio,
	output logic dividedClockOut
);

	logic [RATIO_WIDTH-1:0] countFf;
	logic [RATIO_WIDTH-1:0] nxt_count;
	logic [RATIO_WIDTH-1:0] halfCount;
	logic riseHalfFf;
	logic fallHalfFf;

	// ==========================================================
	// period counter
	assign halfCount = RATIO_WIDTH'((ratio + 1'b1) >> 1);
	assign nxt_count = (countFf >= ratio - 1'b1) ? '0 : countFf + 1'b1;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			countFf <= '0;
		else if (!enable)
			countFf <= '0;
		else
			countFf <= nxt_count;
	end

	// ==========================================================
	// half-cycle trim for odd ratios
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			riseHalfFf <= 1'b0;
		else
			riseHalfFf <= enable && (nxt_count < halfCount);
	end

	always_ff @(negedge clk or posedge rst)
	begin
		if (rst)
			fallHalfFf <= 1'b0;
		else
			fallHalfFf <= riseHalfFf;
	end

	// held low while disabled; even ratios use the plain half
	assign dividedClockOut = ratio[0] ? (riseHalfFf & fallHalfFf) : riseHalfFf;

endmodule : dps_clock_divider

// ---- dps_phase_shift_ctrl.sv ----
// control logic of the clock manager fine phase shift and lock status
//
// What this block does
// - a step takes effect within 100 reference cycles plus three step clock edges.
// - step_done pulses high for exactly one step clock period when done.
// - output phase jumps from old to new setting in one cycle; the slide field ramps only during settle; no glitches.
// - step_done means nothing in none or fixed mode; it stays low.
// - mode is none, fixed or variable, default none; none ignores the numerator.
// - start numerator takes any value -255 to 255, used in fixed and variable.
// - variable mode starts stepping from the configured numerator.
// - status bit zero flags numerator beyond +-255 or delay range exceeded.
// - reset drops the lock indicator.
// - divide and mode settings survive a unit reset.
// - output clocks stop low while in reset.
// - lock asserts only after lock; outputs held off before it.
// - with wait enabled, configuration completion is held until lock.
// - divided clock has 50/50 duty cycle; default ratio is 2.
`timescale 1ns/1ps

module dps_phase_shift_ctrl
	import dps_pkg::*;
#(
	parameter int LOCK_CYCLES = LOCK_REF_CYCLES,
	parameter int SETTLE_CYCLES = SETTLE_REF_CYCLES,
	parameter int RANGE_LIMIT = DELAY_RANGE_LIMIT
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic cfgRst,
	input wire logic [3:0] avmAddress,
	input wire logic avmRead,
	input wire logic avmWrite,
	input wire logic [31:0] avmWritedata,
	input wire logic [3:0] avmByteenable,
	output logic [31:0] avmReaddata,
	output logic avmWaitrequest,
	input wire logic phaseStepClock,
	input wire logic stepRequest,
	input wire logic stepDirection,
	output logic stepDone,
	output logic locked,
	output logic statusOverflow,
	output logic configDoneHold,
	output logic [8:0] appliedOffset,
	output logic dividedClockOut
);

	logic ackFf;
	logic busWrite;
	logic busRead;
	logic [31:0] byteMask;
	logic [31:0] ctrlWord;
	logic [31:0] startWord;
	logic [31:0] statusWord;
	logic [31:0] phaseWord;
	logic [31:0] nxt_ctrl;
	logic [31:0] nxt_start;
	logic [31:0] nxt_readdata;
	dps_mode_type modeFf;
	logic waitEnableFf;
	logic [4:0] ratioFf;
	logic signed [8:0] startFf;
	logic [31:0] readdataFf;
	logic [15:0] lockCountFf;
	logic lockedFf;
	logic stepClockPrevFf;
	logic stepEdge;
	dps_step_type stateFf;
	logic [7:0] settleCountFf;
	logic [7:0] slideFf;
	logic [1:0] edgeCountFf;
	logic dirFf;
	logic signed [9:0] phaseFf;
	logic signed [9:0] nxt_phase;
	logic [9:0] nxt_magnitude;
	logic stepOutOfRange;
	logic applyStep;
	logic overflowFf;
	logic stepDoneFf;
	logic [8:0] appliedOffsetFf;
	logic variableMode;

	// ==========================================================
	// bus slave: one wait cycle, then the answer
	assign avmWaitrequest = (avmRead | avmWrite) & ~ackFf;
	assign busWrite = avmWrite & ~avmWaitrequest;
	assign busRead = avmRead & ~avmWaitrequest;
	assign avmReaddata = readdataFf;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ackFf <= 1'b0;
		else
			ackFf <= (avmRead | avmWrite) & ~ackFf;
	end

	always_comb
	begin
		for (int i = 0; i < 4; i++)
			byteMask[8*i +: 8] = {8{avmByteenable[i]}};
	end

	// ==========================================================
	// register views
	assign ctrlWord = {19'h0_0000, ratioFf, 5'h00, waitEnableFf, modeFf};
	assign startWord = {{23{startFf[8]}}, startFf};
	assign statusWord = {28'h000_0000, configDoneHold, (stateFf != ST_IDLE), lockedFf,
		overflowFf};
	assign phaseWord = {8'h00, slideFf, 7'h00, appliedOffsetFf};
	assign nxt_ctrl = (ctrlWord & ~byteMask) | (avmWritedata & byteMask);
	assign nxt_start = (startWord & ~byteMask) | (avmWritedata & byteMask);

	always_comb
	begin
		case (avmAddress)
			CTRL_OFFSET: nxt_readdata = ctrlWord;
			START_OFFSET: nxt_readdata = startWord;
			STATUS_OFFSET: nxt_readdata = statusWord;
			PHASE_OFFSET: nxt_readdata = phaseWord;
			default: nxt_readdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			readdataFf <= 32'h0000_0000;
		else if (avmRead && !ackFf)
			readdataFf <= nxt_readdata;
	end

	// ==========================================================
	// configuration, cleared only by cfgRst
	always_ff @(posedge clk or posedge cfgRst)
	begin
		if (cfgRst)
		begin
			modeFf <= MODE_RESET;
			waitEnableFf <= 1'b0;
			ratioFf <= RATIO_RESET;
		end
		else if (busWrite && avmAddress == CTRL_OFFSET)
		begin
			case (nxt_ctrl[CTRL_MODE_LSB +: 2])
				MODE_NONE: modeFf <= MODE_NONE;
				MODE_FIXED: modeFf <= MODE_FIXED;
				MODE_VARIABLE: modeFf <= MODE_VARIABLE;
				default: modeFf <= modeFf;
			endcase
			waitEnableFf <= nxt_ctrl[CTRL_WAIT_BIT];
			if (nxt_ctrl[CTRL_RATIO_LSB +: 5] < RATIO_MIN)
				ratioFf <= RATIO_MIN;
			else if (nxt_ctrl[CTRL_RATIO_LSB +: 5] > RATIO_MAX)
				ratioFf <= RATIO_MAX;
			else
				ratioFf <= nxt_ctrl[CTRL_RATIO_LSB +: 5];
		end
	end

	always_ff @(posedge clk or posedge cfgRst)
	begin
		if (cfgRst)
			startFf <= START_RESET;
		else if (busWrite && avmAddress == START_OFFSET)
		begin
			if (nxt_start[8:0] == 9'h100)
				startFf <= NUM_MIN[8:0];
			else
				startFf <= nxt_start[8:0];
		end
	end

	// ==========================================================
	// lock indication
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			lockCountFf <= 16'h0000;
			lockedFf <= 1'b0;
		end
		else if (!lockedFf)
		begin
			lockCountFf <= lockCountFf + 1'b1;
			if (lockCountFf == 16'(LOCK_CYCLES - 1))
				lockedFf <= 1'b1;
		end
	end

	assign locked = lockedFf;
	assign configDoneHold = waitEnableFf & ~lockedFf;

	// ==========================================================
	// step handshake
	assign variableMode = (modeFf == MODE_VARIABLE) && lockedFf;
	assign stepEdge = phaseStepClock & ~stepClockPrevFf;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			stepClockPrevFf <= 1'b0;
		else
			stepClockPrevFf <= phaseStepClock;
	end

	assign nxt_phase = dirFf ? phaseFf + 10'sd1 : phaseFf - 10'sd1;
	assign nxt_magnitude = nxt_phase[9] ? 10'(-nxt_phase) : nxt_phase;
	assign stepOutOfRange = (nxt_phase > NUM_MAX) || (nxt_phase < NUM_MIN)
		|| (nxt_magnitude > 10'(RANGE_LIMIT));
	assign applyStep = (stateFf == ST_SYNC) && stepEdge
		&& (edgeCountFf == 2'(SYNC_STEP_EDGES - 1));

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			stateFf <= ST_IDLE;
			settleCountFf <= 8'h00;
			edgeCountFf <= 2'b00;
			dirFf <= 1'b0;
		end
		else if (!variableMode)
		begin
			stateFf <= ST_IDLE;
			settleCountFf <= 8'h00;
			edgeCountFf <= 2'b00;
		end
		else
		begin
			case (stateFf)
				ST_IDLE:
				begin
					if (stepEdge && stepRequest)
					begin
						stateFf <= ST_SETTLE;
						dirFf <= stepDirection;
						settleCountFf <= 8'h00;
					end
				end
				ST_SETTLE:
				begin
					settleCountFf <= settleCountFf + 1'b1;
					if (settleCountFf == 8'(SETTLE_CYCLES - 1))
					begin
						stateFf <= ST_SYNC;
						edgeCountFf <= 2'b00;
					end
				end
				ST_SYNC:
				begin
					if (stepEdge)
					begin
						edgeCountFf <= edgeCountFf + 1'b1;
						if (applyStep)
							stateFf <= ST_DONE;
					end
				end
				ST_DONE:
				begin
					if (stepEdge && stepRequest)
					begin
						stateFf <= ST_SETTLE;
						dirFf <= stepDirection;
						settleCountFf <= 8'h00;
					end
					else if (stepEdge)
						stateFf <= ST_IDLE;
				end
				default: stateFf <= ST_IDLE;
			endcase
		end
	end

	// requests in settle or sync fall through untouched

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			stepDoneFf <= 1'b0;
		else if (!variableMode)
			stepDoneFf <= 1'b0;
		else if (applyStep)
			stepDoneFf <= 1'b1;
		else if (stepEdge)
			stepDoneFf <= 1'b0;
	end

	assign stepDone = stepDoneFf;

	// ==========================================================
	// phase numerator and gradual slide
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			slideFf <= 8'h00;
		else if (stateFf == ST_SETTLE)
			slideFf <= settleCountFf;
		else
			slideFf <= 8'h00;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			phaseFf <= 10'sd0;
		else if (!lockedFf || modeFf != MODE_VARIABLE)
			phaseFf <= 10'(startFf);
		else if (applyStep && !stepOutOfRange)
			phaseFf <= nxt_phase;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			overflowFf <= 1'b0;
		else if (applyStep && stepOutOfRange)
			overflowFf <= 1'b1;
		else if (busWrite && avmAddress == STATUS_OFFSET
			&& avmByteenable[0] && avmWritedata[STATUS_OVF_BIT])
			overflowFf <= 1'b0;
	end

	assign statusOverflow = overflowFf;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			appliedOffsetFf <= 9'h000;
		else if (modeFf == MODE_NONE || !lockedFf)
			appliedOffsetFf <= 9'h000;
		else
			appliedOffsetFf <= phaseFf[8:0];
	end

	assign appliedOffset = appliedOffsetFf;

	// ==========================================================
	// divided clock, stopped low in reset and before lock
	dps_clock_divider #(
		.RATIO_WIDTH(5)
	) uDivider (
		.clk(clk),
		.rst(rst),
		.enable(lockedFf),
		.ratio(ratioFf),
		.dividedClockOut(dividedClockOut)
	);

endmodule : dps_phase_shift_ctrl

// ---- dps_checker.sv ----
// port assertions for the phase shift control block
`timescale 1ns/1ps
module dps_checker
#(
	parameter int LOCK_CYCLES = 8
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic avmRead,
	input wire logic avmWrite,
	input wire logic avmWaitrequest,
	input wire logic phaseStepClock,
	input wire logic stepRequest,
	input wire logic stepDone,
	input wire logic locked,
	input wire logic configDoneHold,
	input wire logic [8:0] appliedOffset,
	input wire logic dividedClockOut
);
	logic psPrev_ff, busy_ff;
	int edges_ff, lockCnt_ff;
	wire logic psEdge = phaseStepClock && !psPrev_ff;

	// ==========
	// step and lock tracking
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			psPrev_ff <= 1'b0;
			busy_ff <= 1'b0;
			edges_ff <= 0;
			lockCnt_ff <= 0;
		end
		else
		begin
			psPrev_ff <= phaseStepClock;
			if (!locked)
				lockCnt_ff <= lockCnt_ff + 1;
			if (psEdge && stepRequest && locked && !busy_ff)
			begin
				busy_ff <= 1'b1;
				edges_ff <= 0;
			end
			else if (stepDone)
				busy_ff <= 1'b0;
			else if (psEdge && busy_ff)
				edges_ff <= edges_ff + 1;
		end
	end

	// ==========
	// assertions
	a_wait_one: assert property (@(posedge clk) disable iff (rst)
		$rose(avmRead || avmWrite) |-> avmWaitrequest ##1 !avmWaitrequest)
		else $error("bus wait not one cycle");
	a_done_hold: assert property (@(posedge clk) disable iff (rst)
		!psEdge |=> $stable(stepDone))
		else $error("done moved off a step edge");
	a_done_drop: assert property (@(posedge clk) disable iff (rst)
		stepDone && psEdge |=> !stepDone)
		else $error("done longer than one step period");
	a_step_edges: assert property (@(posedge clk) disable iff (rst)
		$rose(stepDone) |-> busy_ff && edges_ff == 3)
		else $error("done not at third step edge");
	a_lock_clear: assert property (@(posedge clk) rst |-> !locked)
		else $error("locked high in reset");
	a_lock_time: assert property (@(posedge clk) disable iff (rst)
		$rose(locked) |-> lockCnt_ff == LOCK_CYCLES)
		else $error("lock time wrong");
	a_out_quiet: assert property (@(posedge clk)
		(rst || !locked) |-> !dividedClockOut)
		else $error("divided clock runs unlocked");
	a_cfg_hold: assert property (@(posedge clk) disable iff (rst)
		locked |-> !configDoneHold)
		else $error("config held while locked");
	a_offset_idle: assert property (@(posedge clk) disable iff (rst)
		!locked |-> appliedOffset == 9'h000)
		else $error("offset applied before lock");
endmodule : dps_checker

// ---- dps_step_master.sv ----
// user logic model driving the phase step handshake
`timescale 1ns/1ps
module dps_step_master
(
	input wire logic clk,
	input wire logic en,
	input wire logic stepDone,
	output logic phaseStepClock,
	output logic stepRequest,
	output logic stepDirection
);
	int div;

	// ==========
	// step clock of eight clk periods
	initial
	begin
		phaseStepClock = 1'b0;
		stepRequest = 1'b0;
		stepDirection = 1'b0;
	end
	always @(posedge clk)
	begin
		div <= en ? div + 1 : 0;
		phaseStepClock <= en && div[2];
		if (!en)
			stepDirection <= 1'b0;
	end

	// ==========
	// one step request
	task automatic step(input logic dir, input logic hold, output int lat);
		@(posedge phaseStepClock);
		stepRequest <= 1'b1;
		stepDirection <= dir;
		@(posedge phaseStepClock);
		stepRequest <= 1'b0;
		stepDirection <= !dir;
		lat = 8;
		while (hold && stepDone !== 1'b1 && lat < 200)
		begin
			@(posedge clk);
			lat++;
		end
	endtask : step
endmodule : dps_step_master

// ---- tb_dynamic_phase_shift_control.sv ----
// testbench for the phase shift control block
`timescale 1ns/1ps
module tb_dynamic_phase_shift_control
	import dps_pkg::*;
;
	logic clk, rst, cfgRst, avmRead, avmWrite, step_request;
	logic [3:0] avmAddress;
	logic [31:0] avmWritedata, avmReaddata, rdata;
	logic avmWaitrequest, phaseStepClock, stepRequest, stepDirection, stepDone;
	logic locked, statusOverflow, configDoneHold, dividedClockOut;
	logic [8:0] appliedOffset;
	int err_count, comparisons;

	dps_phase_shift_ctrl #(.LOCK_CYCLES(8), .SETTLE_CYCLES(4), .RANGE_LIMIT(255)) DUT
	(
		.clk,
		.rst,
		.cfgRst,
		.avmAddress,
		.avmRead,
		.avmWrite,
		.avmWritedata,
		.avmByteenable(4'hF),
		.avmReaddata,
		.avmWaitrequest,
		.phaseStepClock,
		.stepRequest,
		.stepDirection,
		.stepDone,
		.locked,
		.statusOverflow,
		.configDoneHold,
		.appliedOffset,
		.dividedClockOut
	);
	dps_step_master psm
	(
		.clk,
		.en(step_request),
		.stepDone,
		.phaseStepClock,
		.stepRequest,
		.stepDirection
	);

	// ==========
	// shared tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic results;
		if (err_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		avmWrite <= w;
		avmRead <= !w;
		avmAddress <= a;
		avmWritedata <= d;
		do
		begin
			@(posedge clk);
		end
		while (avmWaitrequest !== 1'b0);
		rdata = avmReaddata;
		avmWrite <= 1'b0;
		avmRead <= 1'b0;
	endtask : bus
	task automatic wait_lock;
		int n;
		n = 0;
		while (locked !== 1'b1 && n < 50)
		begin
			@(posedge clk);
			n++;
		end
		check(locked, 1'h1);
	endtask : wait_lock
	task automatic div_chk(input int tgExp);
		int hi, tg;
		logic prev;
		hi = 0;
		tg = 0;
		prev = dividedClockOut;
		repeat (16)
		begin
			@(posedge clk);
			hi += dividedClockOut;
			tg += dividedClockOut ^ prev;
			prev = dividedClockOut;
		end
		check(hi, 32'h0000_0008);
		check(tg, tgExp);
	endtask : div_chk

	// ==========
	// scenarios
	task automatic t_reset;
		wait_lock();
		bus(1'b0, CTRL_OFFSET, 32'h0000_0000);
		check(rdata, 32'h0000_0200);
		bus(1'b0, STATUS_OFFSET, 32'h0000_0000);
		check(rdata, 32'h0000_0002);
		div_chk(16);
	endtask : t_reset
	task automatic t_none;
		bus(1'b1, START_OFFSET, 32'h0000_0005);
		bus(1'b0, START_OFFSET, 32'h0000_0000);
		check(rdata[8:0], 9'h005);
		check(appliedOffset, 9'h000);
		bus(1'b1, CTRL_OFFSET, 32'h0000_1F03);
		bus(1'b0, CTRL_OFFSET, 32'h0000_0000);
		check(rdata, 32'h0000_1000);
	endtask : t_none
	task automatic t_fixed;
		bus(1'b1, CTRL_OFFSET, 32'h0000_0201);
		bus(1'b1, START_OFFSET, 32'h0000_0100);
		bus(1'b0, START_OFFSET, 32'h0000_0000);
		check(rdata[8:0], 9'h101);
		check(appliedOffset, 9'h101);
		check(stepDone, 1'h0);
	endtask : t_fixed
	task automatic t_var;
		int lat;
		bus(1'b1, START_OFFSET, 32'h0000_00FE);
		bus(1'b1, CTRL_OFFSET, 32'h0000_0202);
		repeat (2) @(posedge clk);
		check(appliedOffset, 9'h0FE);
		step_request <= 1'b1;
		psm.step(1'b1, 1'b1, lat);
		check(lat inside {[24:32]}, 1'h1);
		repeat (2) @(posedge clk);
		check(appliedOffset, 9'h0FF);
		psm.step(1'b1, 1'b1, lat);
		check(lat inside {[24:32]}, 1'h1);
		repeat (2) @(posedge clk);
		check(appliedOffset, 9'h0FF);
		check(statusOverflow, 1'h1);
		bus(1'b0, STATUS_OFFSET, 32'h0000_0000);
		check(rdata[1:0], 2'h3);
		bus(1'b1, STATUS_OFFSET, 32'h0000_0001);
		@(posedge clk);
		check(statusOverflow, 1'h0);
		psm.step(1'b0, 1'b0, lat);
		psm.step(1'b0, 1'b1, lat);
		check(lat, 32'h0000_000A);
		repeat (40) @(posedge clk);
		check(appliedOffset, 9'h0FE);
		step_request <= 1'b0;
	endtask : t_var
	task automatic t_rerst;
		bus(1'b1, CTRL_OFFSET, 32'h0000_0406);
		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		check(locked, 1'h0);
		check(dividedClockOut, 1'h0);
		check(configDoneHold, 1'h1);
		rst <= 1'b0;
		wait_lock();
		check(configDoneHold, 1'h0);
		bus(1'b0, CTRL_OFFSET, 32'h0000_0000);
		check(rdata, 32'h0000_0406);
		check(appliedOffset, 9'h0FE);
		div_chk(8);
	endtask : t_rerst

	// ==========
	// clock, watchdog and main sequence
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial
	begin
		#100000;
		err_count++;
		results();
	end
	initial
	begin
		rst = 1'b1;
		cfgRst = 1'b1;
		avmRead = 1'b0;
		avmWrite = 1'b0;
		avmAddress = 4'h0;
		avmWritedata = 32'h0000_0000;
		step_request = 1'b0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		cfgRst <= 1'b0;
		t_reset();
		t_none();
		t_fixed();
		t_var();
		t_rerst();
		results();
	end
endmodule : tb_dynamic_phase_shift_control

bind dps_phase_shift_ctrl dps_checker #(.LOCK_CYCLES(LOCK_CYCLES)) chk
(
	.clk,
	.rst,
	.avmRead,
	.avmWrite,
	.avmWaitrequest,
	.phaseStepClock,
	.stepRequest,
	.stepDone,
	.locked,
	.configDoneHold,
	.appliedOffset,
	.dividedClockOut
);
